// file: core/dms_mode_cmds.v
`include "dms_map.vh"
`timescale 1ns/1ps
`default_nettype none
module dms_mode_cmds #(
  parameter integer DIAG_CYC = `DMS_DIAG_CYC,
  parameter integer LOAD_CYC = `DMS_LOAD_CYC
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       cmd_valid,
  input  wire [7:0] cmd_code,
  input  wire       frame_start,
  input  wire       nmi_event,
  input  wire       idle_mode,
  input  wire       panel_on,
  input  wire       row_order_reverse,
  input  wire       column_order_reverse,
  input  wire       row_column_swap,
  input  wire       refresh_direction,
  input  wire       bgr_order,
  input  wire       inversion_on,
  input  wire       scroll_active,
  input  wire       tearing_line_enable,
  input  wire       tearing_line_mode,
  output reg        rd_valid_ff,
  output reg  [7:0] rd_data_ff,
  output reg        awake_ff,
  output reg        partial_state_ff,
  output reg        scroll_exit_ff,
  output reg        dcdc_en_ff,
  output reg        osc_en_ff,
  output reg        scan_en_ff,
  output reg        host_if_en_ff,
  output reg        mem_retain_ff,
  output reg        diag_run_ff,
  output reg        default_load_ff
);
  localparam [1:0] ST_ASLEEP = 2'b01;
  localparam [1:0] ST_AWAKE  = 2'b10;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg        pend_partial_ff;
  reg        pend_normal_ff;
  reg        nxt_pend_partial;
  reg        nxt_pend_normal;
  reg        soft_rst_ff;
  wire       diag_busy;
  wire       load_busy;
  wire       is_cmd;
  wire       leave_awake;

  function is_op;
    input [7:0] code;
    input [7:0] op;
    begin
      is_op = cmd_valid && (code == op);
    end
  endfunction

  assign is_cmd = cmd_valid;
  // Any of these drops the device back to sleep
  assign leave_awake = is_op(cmd_code, `DMS_CMD_SLEEP_ENTER) ||
                       is_op(cmd_code, `DMS_CMD_SW_RESET) || nmi_event;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_ASLEEP: begin
        // Repeated sleep-enter has no effect here
        if (is_op(cmd_code, `DMS_CMD_SLEEP_EXIT))
          nxt_state = ST_AWAKE;
      end
      ST_AWAKE: begin
        // Repeated sleep-exit has no effect here
        if (leave_awake)
          nxt_state = ST_ASLEEP;
      end
      default: nxt_state = ST_ASLEEP;
    endcase
  end

  always @* begin
    nxt_pend_partial = pend_partial_ff;
    nxt_pend_normal  = pend_normal_ff;
    if (is_op(cmd_code, `DMS_CMD_PARTIAL_ON) && !partial_state_ff) begin
      nxt_pend_partial = 1'b1;
      nxt_pend_normal  = 1'b0;
    end else if (is_op(cmd_code, `DMS_CMD_NORMAL_ON)) begin
      nxt_pend_normal  = 1'b1;
      nxt_pend_partial = 1'b0;
    end else if (frame_start) begin
      nxt_pend_partial = 1'b0;
      nxt_pend_normal  = 1'b0;
    end
    if (is_op(cmd_code, `DMS_CMD_SW_RESET)) begin
      nxt_pend_partial = 1'b0;
      nxt_pend_normal  = 1'b0;
    end
  end

  // Software reset stops wake timing; one-cycle pulse is enough
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      soft_rst_ff <= 1'b0;
    else
      soft_rst_ff <= is_op(cmd_code, `DMS_CMD_SW_RESET);
  end

  dms_wake_timer #(
    .DIAG_CYC (DIAG_CYC),
    .LOAD_CYC (LOAD_CYC)
  ) u_timer (
    .clk          (clk),
    .rstn         (rstn),
    .start        (state_ff == ST_ASLEEP && nxt_state == ST_AWAKE),
    .stop         (nxt_state == ST_ASLEEP || soft_rst_ff),
    .diag_busy_ff (diag_busy),
    .load_busy_ff (load_busy)
  );

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff         <= ST_ASLEEP;
      pend_partial_ff  <= 1'b0;
      pend_normal_ff   <= 1'b0;
      awake_ff         <= 1'b0;
      partial_state_ff <= 1'b0;
      scroll_exit_ff   <= 1'b0;
      dcdc_en_ff       <= 1'b0;
      osc_en_ff        <= 1'b0;
      scan_en_ff       <= 1'b0;
      host_if_en_ff    <= 1'b0;
      mem_retain_ff    <= 1'b0;
      diag_run_ff      <= 1'b0;
      default_load_ff  <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      pend_partial_ff <= nxt_pend_partial;
      pend_normal_ff  <= nxt_pend_normal;
      awake_ff        <= (nxt_state == ST_AWAKE);
      // Power controls follow the sleep state
      dcdc_en_ff      <= (nxt_state == ST_AWAKE);
      osc_en_ff       <= (nxt_state == ST_AWAKE);
      scan_en_ff      <= (nxt_state == ST_AWAKE);
      // Host side and frame memory never power down in sleep; reset clears them
      host_if_en_ff   <= 1'b1;
      mem_retain_ff   <= 1'b1;
      diag_run_ff     <= diag_busy;
      default_load_ff <= load_busy;
      scroll_exit_ff  <= 1'b0;
      if (is_op(cmd_code, `DMS_CMD_SW_RESET)) begin
        partial_state_ff <= 1'b0;
      end else if (frame_start) begin
        // Mode change waits for the frame boundary to avoid tearing
        if (pend_partial_ff)
          partial_state_ff <= 1'b1;
        if (pend_normal_ff) begin
          partial_state_ff <= 1'b0;
          scroll_exit_ff   <= 1'b1;
        end
      end
    end
  end

  // Reads answer one cycle after the command
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= 8'h00;
    end else begin
      rd_valid_ff <= 1'b0;
      if (is_cmd) begin
        case (cmd_code)
          `DMS_CMD_DISP_STATUS: begin
            rd_valid_ff <= 1'b1;
            rd_data_ff  <= 8'h00;
            rd_data_ff[`DMS_DS_IDLE]     <= idle_mode;
            rd_data_ff[`DMS_DS_PARTIAL]  <= partial_state_ff;
            rd_data_ff[`DMS_DS_AWAKE]    <= awake_ff;
            rd_data_ff[`DMS_DS_NORMAL]   <= ~partial_state_ff;
            rd_data_ff[`DMS_DS_PANEL_ON] <= panel_on;
          end
          `DMS_CMD_ACCESS_ORDER: begin
            rd_valid_ff <= 1'b1;
            rd_data_ff  <= 8'h00;
            rd_data_ff[`DMS_AO_ROW]     <= row_order_reverse;
            rd_data_ff[`DMS_AO_COL]     <= column_order_reverse;
            rd_data_ff[`DMS_AO_SWAP]    <= row_column_swap;
            rd_data_ff[`DMS_AO_REFRESH] <= refresh_direction;
            rd_data_ff[`DMS_AO_BGR]     <= bgr_order;
          end
          `DMS_CMD_IMAGE_MODE: begin
            rd_valid_ff <= 1'b1;
            rd_data_ff  <= 8'h00;
            rd_data_ff[`DMS_IM_SCROLL] <= scroll_active;
            rd_data_ff[`DMS_IM_INV]    <= inversion_on;
          end
          `DMS_CMD_SIGNAL_MODE: begin
            rd_valid_ff <= 1'b1;
            rd_data_ff  <= 8'h00;
            rd_data_ff[`DMS_SM_TEARING_LINE_ENABLE]   <= tearing_line_enable;
            rd_data_ff[`DMS_SM_TE_MODE] <= tearing_line_mode;
          end
          default: rd_valid_ff <= 1'b0;
        endcase
      end
    end
  end
endmodule // dms_mode_cmds
`default_nettype wire

// file: include/dms_map.vh
`ifndef DMS_MAP_VH
`define DMS_MAP_VH
// Command codes
`define DMS_CMD_NOP          8'h00
`define DMS_CMD_SW_RESET     8'h01
`define DMS_CMD_DISP_STATUS  8'h0a
`define DMS_CMD_ACCESS_ORDER 8'h0b
`define DMS_CMD_IMAGE_MODE   8'h0d
`define DMS_CMD_SIGNAL_MODE  8'h0e
`define DMS_CMD_SLEEP_ENTER  8'h10
`define DMS_CMD_SLEEP_EXIT   8'h11
`define DMS_CMD_PARTIAL_ON   8'h12
`define DMS_CMD_NORMAL_ON    8'h13
// Read-back byte bit positions
`define DMS_DS_IDLE          6
`define DMS_DS_PARTIAL       5
`define DMS_DS_AWAKE         4
`define DMS_DS_NORMAL        3
`define DMS_DS_PANEL_ON      2
`define DMS_AO_ROW           7
`define DMS_AO_COL           6
`define DMS_AO_SWAP          5
`define DMS_AO_REFRESH       4
`define DMS_AO_BGR           3
`define DMS_IM_SCROLL        7
`define DMS_IM_INV           5
`define DMS_SM_TEARING_LINE_ENABLE         7
`define DMS_SM_TE_MODE       6
// Timing in microseconds, clock in MHz
`define DMS_CLK_MHZ          250
`define DMS_DIAG_US          5000
`define DMS_LOAD_US          120000
`define DMS_DIAG_CYC         (`DMS_DIAG_US * `DMS_CLK_MHZ)
`define DMS_LOAD_CYC         (`DMS_LOAD_US * `DMS_CLK_MHZ)
`endif

// file: core/dms_wake_timer.v
`timescale 1ns/1ps
`default_nettype none
// Counts the wake-up windows after a sleep exit
module dms_wake_timer #(
  parameter integer DIAG_CYC = 1250000,
  parameter integer LOAD_CYC = 30000000
) (
  input  wire clk,
  input  wire rstn,
  input  wire start,
  input  wire stop,
  output reg  diag_busy_ff,
  output reg  load_busy_ff
);
  reg  [31:0] cnt_ff;
  wire [31:0] cnt_inc;

  assign cnt_inc = cnt_ff + 32'h00000001;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff       <= 32'h00000000;
      diag_busy_ff <= 1'b0;
      load_busy_ff <= 1'b0;
    end else if (stop) begin
      cnt_ff       <= 32'h00000000;
      diag_busy_ff <= 1'b0;
      load_busy_ff <= 1'b0;
    end else if (start) begin
      cnt_ff       <= 32'h00000000;
      diag_busy_ff <= 1'b1;
      load_busy_ff <= 1'b1;
    end else if (load_busy_ff) begin
      cnt_ff <= cnt_inc;
      if (cnt_inc >= DIAG_CYC)
        diag_busy_ff <= 1'b0;
      if (cnt_inc >= LOAD_CYC)
        load_busy_ff <= 1'b0;
    end
  end
endmodule // dms_wake_timer
`default_nettype wire

// file: bench/dms_host.sv
`timescale 1ns/1ps
`default_nettype none
module dms_host #(
  parameter integer GAP = 130
) (
  input  wire             clk,
  output var logic        cmd_valid,
  output var logic [7:0]  cmd_code
);
  integer pend = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
  end
  // One command per call; the byte is turned over on release so nothing stale lingers
  task automatic send(input logic [7:0] c);
    repeat (pend) @(posedge clk);
    pend = 0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code  = c;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code  = ~c;
    if (c == 8'h10 || c == 8'h11) pend = GAP;
  endtask
endmodule // dms_host
`default_nettype wire

// file: bench/dms_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dms_chk (
  input wire       clk,
  input wire       rstn,
  input wire       cmd_valid,
  input wire [7:0] cmd_code,
  input wire       frame_start,
  input wire       nmi_event,
  input wire       idle_mode,
  input wire       panel_on,
  input wire       rd_valid_ff,
  input wire [7:0] rd_data_ff,
  input wire       awake_ff,
  input wire       partial_state_ff,
  input wire       dcdc_en_ff,
  input wire       osc_en_ff,
  input wire       scan_en_ff,
  input wire       host_if_en_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire p = partial_state_ff;
  a_read_status_byte:
    assert property (cmd_valid && cmd_code == 8'h0a |=> rd_valid_ff && rd_data_ff[6:2] ==
      {$past(idle_mode), $past(p), $past(awake_ff), !$past(p), $past(panel_on)})
    else $error("status byte wrong");
  a_sleep_power_off:
    assert property (cmd_valid && cmd_code == 8'h10 |=>
      !(awake_ff || dcdc_en_ff || osc_en_ff || scan_en_ff)) else $error("sleep left power on");
  a_wake_power_on:
    assert property (cmd_valid && cmd_code == 8'h11 && !awake_ff |=>
      awake_ff && dcdc_en_ff && osc_en_ff && scan_en_ff) else $error("wake incomplete");
  a_asleep_stays:
    assert property (!awake_ff && !(cmd_valid && cmd_code == 8'h11) |=> !awake_ff)
    else $error("woke without exit");
  a_awake_stays:
    assert property (awake_ff && !nmi_event && !(cmd_valid && (cmd_code == 8'h10 ||
      cmd_code == 8'h01)) |=> awake_ff) else $error("slept without cause");
  a_host_alive:
    assert property ($past(rstn) |-> host_if_en_ff) else $error("host side dropped");
  a_partial_on_frame:
    assert property ($rose(p) |-> $past(frame_start)) else $error("partial off frame");
  a_partial_off_cause:
    assert property ($fell(p) |-> $past(frame_start) || $past(cmd_valid && cmd_code == 8'h01))
    else $error("partial dropped");
  a_swreset_state:
    assert property (cmd_valid && cmd_code == 8'h01 |=> !awake_ff && !p)
    else $error("soft reset state");
  cover property (cmd_valid && cmd_code == 8'h11 && !awake_ff);
  cover property ($rose(p));
  cover property (nmi_event && awake_ff);
endmodule // dms_chk
bind dms_mode_cmds dms_chk u_chk (.clk, .rstn, .cmd_valid, .cmd_code, .frame_start,
  .nmi_event, .idle_mode, .panel_on, .rd_valid_ff, .rd_data_ff, .awake_ff,
  .partial_state_ff, .dcdc_en_ff, .osc_en_ff, .scan_en_ff, .host_if_en_ff);
`default_nettype wire

// file: bench/display_mode_status_cmds_tb.sv
`timescale 1ns/1ps
`default_nettype none
module display_mode_status_cmds_tb;
  logic clk, rstn, frame_start, nmi_event;
  logic [10:0] lv;
  wire cmd_valid, rd_valid_ff, awake_ff, partial_state_ff, scroll_exit_ff;
  wire dcdc_en_ff, osc_en_ff, scan_en_ff, host_if_en_ff, mem_retain_ff;
  wire diag_run_ff, default_load_ff;
  wire [7:0] cmd_code, rd_data_ff;
  integer mismatches = 0, n_compared = 0;
  dms_host h (.clk, .cmd_valid, .cmd_code);
  dms_mode_cmds #(.DIAG_CYC(20), .LOAD_CYC(100)) dut (
    .clk, .rstn, .cmd_valid, .cmd_code, .frame_start, .nmi_event,
    .idle_mode(lv[10]), .panel_on(lv[9]), .row_order_reverse(lv[8]),
    .column_order_reverse(lv[7]), .row_column_swap(lv[6]), .refresh_direction(lv[5]),
    .bgr_order(lv[4]), .inversion_on(lv[3]), .scroll_active(lv[2]),
    .tearing_line_enable(lv[1]), .tearing_line_mode(lv[0]), .rd_valid_ff, .rd_data_ff,
    .awake_ff, .partial_state_ff, .scroll_exit_ff, .dcdc_en_ff, .osc_en_ff, .scan_en_ff,
    .host_if_en_ff, .mem_retain_ff, .diag_run_ff, .default_load_ff);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, input logic aw, input logic pt);
    logic [7:0] e;
    case (c)
      8'h0a: e = {1'b0, lv[10], pt, aw, !pt, lv[9], 2'b00};
      8'h0b: e = {lv[8:4], 3'b000};
      8'h0d: e = {lv[2], 1'b0, lv[3], 5'b00000};
      default: e = {lv[1:0], 6'b000000};
    endcase
    h.send(c);
    chk("rd_valid", 8'h01, rd_valid_ff);
    chk("rd_data", e, rd_data_ff);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask
  task automatic t_reset;
    #1 rstn = 1'b0;
    repeat (5) @(posedge clk);
    chk("in_reset", 8'h00, {awake_ff, partial_state_ff, host_if_en_ff, diag_run_ff});
    #1 rstn = 1'b1;
    @(posedge clk);
    #1 chk("host_mem", 8'h03, {host_if_en_ff, mem_retain_ff});
    rd(8'h0a, 1'b0, 1'b0);
  endtask
  task automatic t_reads;
    logic [10:0] pat [4] = '{11'h000, 11'h7ff, 11'h555, 11'h2aa};
    logic [7:0] cds [4] = '{8'h0a, 8'h0b, 8'h0d, 8'h0e};
    foreach (pat[i]) begin
      lv = pat[i];
      foreach (cds[j]) rd(cds[j], 1'b0, 1'b0);
    end
    h.send(8'h0c);
    chk("no_read", 8'h00, rd_valid_ff);
  endtask
  task automatic t_sleep;
    h.send(8'h10);
    chk("asleep", 8'h00, awake_ff);
    h.send(8'h11);
    chk("wake", 8'h0f, {awake_ff, dcdc_en_ff, osc_en_ff, scan_en_ff});
    // Busy flags trail the wake by one cycle, re-registered from the timer outputs into diag_run_ff and default_load_ff
    @(posedge clk);
    #1 chk("diag_start", 8'h03, {diag_run_ff, default_load_ff});
    repeat (30) @(posedge clk);
    chk("diag_done", 8'h01, {diag_run_ff, default_load_ff});
    h.send(8'h11);
    chk("exit_ignored", 8'h02, {awake_ff, diag_run_ff});
    pulse(nmi_event);
    chk("nmi_sleep", 8'h00, awake_ff);
    h.send(8'h11);
    h.send(8'h10);
    chk("sleep", 8'h03, {awake_ff, dcdc_en_ff, osc_en_ff, scan_en_ff, host_if_en_ff,
      mem_retain_ff});
  endtask
  task automatic t_part;
    h.send(8'h11);
    h.send(8'h12);
    repeat (3) @(posedge clk);
    chk("partial_wait", 8'h00, partial_state_ff);
    pulse(frame_start);
    chk("partial_on", 8'h01, partial_state_ff);
    rd(8'h0a, 1'b1, 1'b1);
    h.send(8'h12);
    pulse(frame_start);
    chk("partial_again", 8'h01, partial_state_ff);
    h.send(8'h13);
    chk("normal_wait", 8'h01, partial_state_ff);
    pulse(frame_start);
    chk("normal", 8'h01, {partial_state_ff, scroll_exit_ff});
    h.send(8'h12);
    pulse(frame_start);
    h.send(8'h01);
    chk("sw_reset", 8'h00, {awake_ff, partial_state_ff});
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report;
  end
  initial begin
    rstn = 1'b0;
    frame_start = 1'b0;
    nmi_event = 1'b0;
    lv = 11'h000;
    t_reset;
    t_reads;
    t_sleep;
    t_part;
    h.send(8'h11);
    t_reset;
    final_report;
  end
endmodule // display_mode_status_cmds_tb
`default_nettype wire
